// ---- core/dma_map.vh ----
// Purpose: Register offsets, fields and codes of the multichannel DMA controller.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Definitions only.
`ifndef DMA_MAP_VH
`define DMA_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define OFF_CFG 8'h00
`define OFF_CTLBASE 8'h04
`define OFF_ALTBASE 8'h08
`define OFF_SWREQ 8'h0C
`define OFF_ENABLE 8'h10
`define OFF_BURST 8'h14
`define OFF_REQMASK 8'h18
`define OFF_ALTUSE 8'h1C
`define OFF_PRIO 8'h20
`define OFF_ERR 8'h24
`define OFF_STATUS 8'h28

// ****************************************
// Fields and reset values
// ****************************************
`define CFG_EN_BIT 0
`define BASE_ALIGN_LSB 10
`define RST_WORD 32'h0000_0000
`define CTL_MODE_MSB 2
`define CTL_CNT_LSB 4
`define CTL_CNT_MSB 13
`define CTL_SIZE_LSB 24
`define CTL_SINC_LSB 26
`define CTL_DINC_LSB 30
`define STRUCT_BYTES 16

// ****************************************
// Transfer modes
// ****************************************
`define MODE_STOP 3'h0
`define MODE_BASIC 3'h1
`define MODE_AUTO 3'h2
`define MODE_PINGPONG 3'h3
`define MODE_MEM_SG 3'h4
`define MODE_PER_SG 3'h6

// ****************************************
// Item sizes and address steps
// ****************************************
`define SIZE_WORD 2'h2
`define INC_NONE 2'h3

`endif

// ---- core/dma_channel_arbiter.v ----
// Purpose: Picks the next channel to serve from the pending set.
// Assumes: Pending and priority vectors come from the same clock domain.
// Notes: Purely combinational.
`timescale 1ns/10ps
module dma_channel_arbiter #(
	parameter N = 32,
	parameter CW = 5
) (
	input wire [N-1:0] pend_i,
	input wire [N-1:0] high_i,
	output reg gnt_valid_o,
	output reg [CW-1:0] gnt_idx_o
);

	integer i;
	reg [N-1:0] hi_pend;

	// ****************************************
	// High level first, lowest index first
	// ****************************************
	always @* begin
		hi_pend = pend_i & high_i;
		gnt_valid_o = |pend_i;
		gnt_idx_o = {CW{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (pend_i[i]) begin
				gnt_idx_o = i[CW-1:0];
			end
		end
		if (|hi_pend) begin
			for (i = N - 1; i >= 0; i = i - 1) begin
				if (hi_pend[i]) begin
					gnt_idx_o = i[CW-1:0];
				end
			end
		end
	end

endmodule

// ---- core/multichannel_dma_controller.v ----
// Purpose: Multichannel DMA engine driven by a control table in system memory.
// Assumes: Peripherals and memory bus share ref_clk_i; mem_ack_i ends each access.
// Notes: One engine serves one channel at a time.
//
// Behaviour
// - basic mode moves only while request held
// - auto mode finishes whole count once started
// - ping-pong swaps structures at each completion
// - memory scatter-gather runs task list
// - peripheral scatter-gather paced by request
// - item size byte, halfword or word
// - addresses step by size or stay
// - two priority levels, high served first
// - memory access only when processor idle
// - software request starts any enabled channel
// - full table spans 1024 bytes
// - enable clears itself on completion
// - remaining count written back, zero when done
// - stopped mode written back on completion
// - per-channel enabled status readable
// - own interrupt only software completion, errors
// - peripheral completion goes to peripheral
// - completion interrupts clear themselves
// - bus error sticky until software clears
// - primary and alternate structure per channel
// - request mask ignores peripheral request
// - burst-only ignores single requests
// - alternate-use picks next structure
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "dma_map.vh"
module multichannel_dma_controller #(
	parameter N = 32,
	parameter CW = 5
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [N-1:0] periph_burst_req_i,
	input wire [N-1:0] periph_single_req_i,
	output reg [N-1:0] periph_done_o,
	output wire irq_o,
	input wire cpu_busy_i,
	output wire mem_req_o,
	output reg mem_we_o,
	output reg [31:0] mem_addr_o,
	output reg [31:0] mem_wdata_o,
	output reg [1:0] mem_size_o,
	input wire mem_ack_i,
	input wire mem_err_i,
	input wire [31:0] mem_rdata_i
);

	localparam [5:0] ST_IDLE = 6'b000001;
	localparam [5:0] ST_LD = 6'b000010;
	localparam [5:0] ST_CP = 6'b000100;
	localparam [5:0] ST_RD = 6'b001000;
	localparam [5:0] ST_WR = 6'b010000;
	localparam [5:0] ST_WB = 6'b100000;

	reg glob_en;
	reg [31:0] ctl_base;
	reg [N-1:0] en, burst_only, req_mask, alt_use, high_pri;
	reg [N-1:0] sw_pend, hold, sg_run;
	reg err;
	reg sw_done;
	reg [5:0] state;
	reg [CW-1:0] ch;
	reg sel, ph, fin;
	reg [1:0] widx;
	reg [31:0] src, dst, ctl, buf_data;
	reg mem_act;

	wire [N-1:0] hw_req;
	wire [N-1:0] pend;
	wire gnt_valid;
	wire [CW-1:0] gnt_idx;
	wire take;
	wire wr_acc;
	wire rd_setup;
	wire [2:0] mode;
	wire [9:0] cnt;
	wire [31:0] ctl_dec;
	wire [31:0] ctl_out;
	wire last_word;

	// ****************************************
	// Helper functions
	// ****************************************
	function [31:0] step_of;
		input [1:0] inc;
		begin
			case (inc)
				2'h0: step_of = 32'h0000_0001;
				2'h1: step_of = 32'h0000_0002;
				2'h2: step_of = 32'h0000_0004;
				default: step_of = 32'h0000_0000;
			endcase
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = (a <= `OFF_STATUS) && (a[1:0] == 2'b00);
		end
	endfunction

	function [31:0] struct_addr;
		input [31:0] base;
		input s;
		input [CW-1:0] c;
		input [1:0] w;
		begin
			struct_addr = base + (s ? N * `STRUCT_BYTES : 0) + c * `STRUCT_BYTES + w * 4;
		end
	endfunction

	// ****************************************
	// Request qualification and arbitration
	// ****************************************
	assign hw_req = ~req_mask & (periph_burst_req_i | (periph_single_req_i & ~burst_only));
	assign pend = {N{glob_en}} & en & (sw_pend | hold | hw_req);

	dma_channel_arbiter #(
		.N(N),
		.CW(CW)
	) u_arb (
		.pend_i(pend),
		.high_i(high_pri),
		.gnt_valid_o(gnt_valid),
		.gnt_idx_o(gnt_idx)
	);

	// ****************************************
	// Memory port
	// ****************************************
	assign mode = ctl[`CTL_MODE_MSB:0];
	assign cnt = ctl[`CTL_CNT_MSB:`CTL_CNT_LSB];
	assign ctl_dec = {ctl[31:`CTL_CNT_MSB+1], cnt - 10'd1, ctl[`CTL_CNT_LSB-1:0]};
	assign ctl_out = fin ? {ctl[31:`CTL_MODE_MSB+1], `MODE_STOP} : ctl;
	assign mem_req_o = mem_act & ~cpu_busy_i;
	assign take = mem_req_o & mem_ack_i;
	assign last_word = (widx == 2'd2);

	always @* begin
		mem_act = 1'b1;
		mem_we_o = 1'b0;
		mem_size_o = `SIZE_WORD;
		mem_wdata_o = buf_data;
		mem_addr_o = struct_addr(ctl_base, sel, ch, widx);
		case (state)
			ST_LD: begin
				mem_we_o = 1'b0;
			end
			ST_CP: begin
				mem_we_o = ph;
				if (!ph) begin
					mem_addr_o = src + {28'h000_0000, widx, 2'b00};
				end else begin
					mem_addr_o = struct_addr(ctl_base, 1'b1, ch, widx);
				end
			end
			ST_RD: begin
				mem_addr_o = src;
				mem_size_o = ctl[`CTL_SIZE_LSB+1:`CTL_SIZE_LSB];
			end
			ST_WR: begin
				mem_we_o = 1'b1;
				mem_addr_o = dst;
				mem_size_o = ctl[`CTL_SIZE_LSB+1:`CTL_SIZE_LSB];
			end
			ST_WB: begin
				mem_we_o = 1'b1;
				case (widx)
					2'd0: mem_wdata_o = src;
					2'd1: mem_wdata_o = dst;
					default: mem_wdata_o = ctl_out;
				endcase
			end
			default: begin
				mem_act = 1'b0;
			end
		endcase
	end

	// ****************************************
	// APB slave
	// ****************************************
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped(paddr);
	assign wr_acc = psel & penable & pwrite & mapped(paddr);
	assign rd_setup = psel & ~penable & ~pwrite;
	assign irq_o = sw_done | err;

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			prdata <= `RST_WORD;
		end else if (rd_setup) begin
			case (paddr)
				`OFF_CFG: prdata <= {31'h0000_0000, glob_en};
				`OFF_CTLBASE: prdata <= ctl_base;
				`OFF_ALTBASE: prdata <= ctl_base + N * `STRUCT_BYTES;
				`OFF_ENABLE: prdata <= {{(32-N){1'b0}}, en};
				`OFF_BURST: prdata <= {{(32-N){1'b0}}, burst_only};
				`OFF_REQMASK: prdata <= {{(32-N){1'b0}}, req_mask};
				`OFF_ALTUSE: prdata <= {{(32-N){1'b0}}, alt_use};
				`OFF_PRIO: prdata <= {{(32-N){1'b0}}, high_pri};
				`OFF_ERR: prdata <= {31'h0000_0000, err};
				`OFF_STATUS: prdata <= {18'h0_0000, state, 3'h0, {(5-CW){1'b0}}, ch};
				default: prdata <= `RST_WORD;
			endcase
		end
	end

	// ****************************************
	// Engine and control state
	// ****************************************
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			glob_en <= 1'b0;
			ctl_base <= `RST_WORD;
			en <= {N{1'b0}};
			burst_only <= {N{1'b0}};
			req_mask <= {N{1'b0}};
			alt_use <= {N{1'b0}};
			high_pri <= {N{1'b0}};
			sw_pend <= {N{1'b0}};
			hold <= {N{1'b0}};
			sg_run <= {N{1'b0}};
			err <= 1'b0;
			sw_done <= 1'b0;
			periph_done_o <= {N{1'b0}};
			state <= ST_IDLE;
			ch <= {CW{1'b0}};
			sel <= 1'b0;
			ph <= 1'b0;
			fin <= 1'b0;
			widx <= 2'd0;
			src <= `RST_WORD;
			dst <= `RST_WORD;
			ctl <= `RST_WORD;
			buf_data <= `RST_WORD;
		end else begin
			sw_done <= 1'b0;
			periph_done_o <= {N{1'b0}};
			if (wr_acc) begin
				case (paddr)
					`OFF_CFG: glob_en <= pwdata[`CFG_EN_BIT];
					`OFF_CTLBASE: ctl_base <= {pwdata[31:`BASE_ALIGN_LSB], 10'h000};
					`OFF_ENABLE: begin
						en <= pwdata[N-1:0];
						hold <= hold & pwdata[N-1:0];
						sw_pend <= sw_pend & pwdata[N-1:0];
					end
					`OFF_BURST: burst_only <= pwdata[N-1:0];
					`OFF_REQMASK: req_mask <= pwdata[N-1:0];
					`OFF_ALTUSE: alt_use <= pwdata[N-1:0];
					`OFF_PRIO: high_pri <= pwdata[N-1:0];
					`OFF_ERR: err <= err & ~pwdata[0];
					default: glob_en <= glob_en;
				endcase
			end
			case (state)
				ST_IDLE: begin
					if (glob_en && gnt_valid) begin
						ch <= gnt_idx;
						sel <= alt_use[gnt_idx];
						widx <= 2'd0;
						ph <= 1'b0;
						fin <= 1'b0;
						state <= ST_LD;
					end
				end
				ST_LD: begin
					if (take) begin
						widx <= widx + 2'd1;
						if (widx == 2'd0) begin
							src <= mem_rdata_i;
						end else if (widx == 2'd1) begin
							dst <= mem_rdata_i;
						end else begin
							ctl <= mem_rdata_i;
							widx <= 2'd0;
							if (mem_rdata_i[`CTL_MODE_MSB:0] == `MODE_STOP ||
								mem_rdata_i[`CTL_CNT_MSB:`CTL_CNT_LSB] == 10'd0) begin
								en[ch] <= 1'b0;
								hold[ch] <= 1'b0;
								sg_run[ch] <= 1'b0;
								sw_pend[ch] <= 1'b0;
								sw_done <= sw_pend[ch];
								periph_done_o[ch] <= ~sw_pend[ch];
								state <= ST_IDLE;
							end else if (!sel && (mem_rdata_i[`CTL_MODE_MSB:0] == `MODE_MEM_SG ||
								mem_rdata_i[`CTL_MODE_MSB:0] == `MODE_PER_SG)) begin
								sg_run[ch] <= 1'b1;
								hold[ch] <= (mem_rdata_i[`CTL_MODE_MSB:0] == `MODE_MEM_SG);
								state <= ST_CP;
							end else begin
								if (mem_rdata_i[`CTL_MODE_MSB:0] == `MODE_AUTO) begin
									hold[ch] <= 1'b1;
								end
								state <= ST_RD;
							end
						end
					end
				end
				ST_CP: begin
					if (take) begin
						ph <= ~ph;
						if (!ph) begin
							buf_data <= mem_rdata_i;
						end else if (last_word) begin
							widx <= 2'd0;
							src <= src + `STRUCT_BYTES;
							ctl <= ctl_dec;
							state <= ST_WB;
						end else begin
							widx <= widx + 2'd1;
						end
					end
				end
				ST_RD: begin
					if (take) begin
						buf_data <= mem_rdata_i;
						state <= ST_WR;
					end
				end
				ST_WR: begin
					if (take) begin
						ctl <= ctl_dec;
						src <= src + step_of(ctl[`CTL_SINC_LSB+1:`CTL_SINC_LSB]);
						dst <= dst + step_of(ctl[`CTL_DINC_LSB+1:`CTL_DINC_LSB]);
						widx <= 2'd0;
						if (cnt == 10'd1) begin
							fin <= 1'b1;
							state <= ST_WB;
						end else if (!en[ch] || !glob_en) begin
							state <= ST_WB;
						end else if (mode != `MODE_AUTO && mode != `MODE_MEM_SG &&
							!hold[ch] && !sw_pend[ch] && !hw_req[ch]) begin
							state <= ST_WB;
						end else begin
							state <= ST_RD;
						end
					end
				end
				ST_WB: begin
					if (take) begin
						widx <= widx + 2'd1;
						if (last_word) begin
							widx <= 2'd0;
							state <= ST_IDLE;
							if (!fin) begin
								if (sg_run[ch] && !sel) begin
									alt_use[ch] <= 1'b1;
								end
							end else if (mode == `MODE_PINGPONG) begin
								alt_use[ch] <= ~sel;
								periph_done_o[ch] <= ~sw_pend[ch];
							end else if (sg_run[ch] && sel) begin
								alt_use[ch] <= 1'b0;
							end else begin
								en[ch] <= 1'b0;
								hold[ch] <= 1'b0;
								sw_pend[ch] <= 1'b0;
								sw_done <= sw_pend[ch];
								periph_done_o[ch] <= ~sw_pend[ch];
							end
						end
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
			if (take && mem_err_i) begin
				err <= 1'b1;
				en[ch] <= 1'b0;
				hold[ch] <= 1'b0;
				sg_run[ch] <= 1'b0;
				sw_pend[ch] <= 1'b0;
				state <= ST_IDLE;
			end
			if (wr_acc && paddr == `OFF_SWREQ) begin
				sw_pend <= sw_pend | (pwdata[N-1:0] & en);
			end
		end
	end

endmodule

// ---- tb/dma_mem_model.sv ----
// Purpose: System memory seen by the DMA engine on the shared bus.
// Assumes: Word accesses; addresses below 4 KiB.
// Notes: Slow mode waits four cycles; stale read data is inverted each cycle.
`timescale 1ns/10ps
module dma_mem_model (
	input wire clk_i,
	input wire req_i,
	input wire we_i,
	input wire [31:0] addr_i,
	input wire [31:0] wdata_i,
	input wire slow_i,
	input wire fail_i,
	output logic ack_o,
	output logic err_o,
	output logic [31:0] rdata_o
);
	logic [31:0] mem [0:1023];
	logic [1:0] wait_q;
	initial begin
		ack_o = 1'b0;
		err_o = 1'b0;
		rdata_o = 32'h0000_0000;
		wait_q = 2'h0;
	end
	// The table region holds a full 1024-byte control table.
	always @(posedge clk_i) begin
		ack_o <= 1'b0;
		err_o <= 1'b0;
		rdata_o <= ~rdata_o;
		if (req_i && !ack_o) begin
			wait_q <= wait_q + 2'h1;
			if (!slow_i || wait_q == 2'h3) begin
				ack_o <= 1'b1;
				err_o <= fail_i;
				wait_q <= 2'h0;
				rdata_o <= mem[addr_i[11:2]];
			end
		end
		if (req_i && ack_o && we_i)
			mem[addr_i[11:2]] <= wdata_i;
	end
endmodule

// ---- tb/dma_checker_properties.sv ----
// Purpose: Port-level assertions for the DMA controller.
// Assumes: One clock, synchronous active-low reset.
// Notes: Bound to every controller instance.
`timescale 1ns/10ps
`include "dma_map.vh"
module dma_checker #(
	parameter N = 32
) (
	input wire ref_clk_i,
	input wire rst_n_i,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pslverr,
	input wire [N-1:0] periph_done_o,
	input wire irq_o,
	input wire cpu_busy_i,
	input wire mem_req_o,
	input wire mem_we_o,
	input wire [31:0] mem_addr_o,
	input wire [31:0] mem_wdata_o,
	input wire mem_ack_i,
	input wire mem_err_i
);
	// ********
	// Shadow state
	// ********
	wire wr_ack = mem_req_o & mem_ack_i & mem_we_o;
	wire any_done = |periph_done_o;
	wire apb_wr = psel & penable & pwrite;
	reg err_seen;
	reg glb_on;
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			err_seen <= 1'b0;
			glb_on <= 1'b0;
		end else begin
			if (apb_wr && paddr == `OFF_ERR && pwdata[0])
				err_seen <= 1'b0;
			if (mem_req_o && mem_ack_i && mem_err_i)
				err_seen <= 1'b1;
			if (apb_wr && paddr == `OFF_CFG)
				glb_on <= pwdata[`CFG_EN_BIT];
		end
	end
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	bus_yield_a: assert property (cpu_busy_i |-> !mem_req_o)
		else $error("bus taken while busy");
	req_hold_a: assert property (mem_req_o && !mem_ack_i ##1 mem_req_o
		|-> $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o))
		else $error("request changed before ack");
	err_sticky_a: assert property (err_seen |-> irq_o)
		else $error("error interrupt dropped");
	apb_refuse_a: assert property (psel && penable
		|-> pslverr == (paddr > 8'h28 || paddr[1:0] != 2'h0))
		else $error("wrong slave error");
	done_pulse_a: assert property (any_done |=> (periph_done_o & $past(periph_done_o)) == 0)
		else $error("done held too long");
	done_cause_a: assert property ($rose(any_done) |-> $past(wr_ack) || $past(wr_ack, 2))
		else $error("done without writeback");
	irq_cause_a: assert property ($rose(irq_o)
		|-> err_seen || $past(wr_ack) || $past(wr_ack, 2))
		else $error("interrupt without cause");
	global_gate_a: assert property (!glb_on |-> !mem_req_o)
		else $error("access while globally off");
endmodule
bind multichannel_dma_controller dma_checker #(.N(N)) chk (.ref_clk_i(ref_clk_i),
	.rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pslverr(pslverr), .periph_done_o(periph_done_o), .irq_o(irq_o),
	.cpu_busy_i(cpu_busy_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
	.mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
	.mem_err_i(mem_err_i));

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the multichannel DMA controller.
// Assumes: Four channels; table at 0x400, sources at 0x800, targets at 0x900.
// Notes: Memory model words are loaded and inspected directly.
`timescale 1ns/10ps
`include "dma_map.vh"
module tb;
	localparam logic [31:0] W0 = 32'h0000_0000;
	localparam logic [31:0] W1 = 32'h0000_0001;
	localparam logic [31:0] W2 = 32'h0000_0002;
	localparam logic [31:0] AUTO2 = 32'h8A00_0022;
	logic ref_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = W0;
	logic [3:0] breq = 4'h0;
	logic [3:0] sreq = 4'h0;
	logic busy = 1'b0;
	logic slow = 1'b0;
	logic fail = 1'b0;
	logic sv;
	logic [31:0] rd;
	logic [1:0] sz;
	wire [31:0] prdata, maddr, mwdata, mrdata;
	wire [3:0] done;
	wire [1:0] msize;
	wire pready, pslverr, irq, mreq, mwe, mack, merr;
	int errors = 0;
	int checks_done = 0;
	multichannel_dma_controller #(.N(4), .CW(2)) uut (.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .periph_burst_req_i(breq), .periph_single_req_i(sreq),
		.periph_done_o(done), .irq_o(irq), .cpu_busy_i(busy), .mem_req_o(mreq),
		.mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwdata), .mem_size_o(msize),
		.mem_ack_i(mack), .mem_err_i(merr), .mem_rdata_i(mrdata));
	dma_mem_model mdl (.clk_i(ref_clk_i), .req_i(mreq), .we_i(mwe), .addr_i(maddr),
		.wdata_i(mwdata), .slow_i(slow), .fail_i(fail), .ack_o(mack), .err_o(merr),
		.rdata_o(mrdata));
	initial forever #5 ref_clk_i = ~ref_clk_i;
	// Keeps the item size of the latest data write into the target area.
	always @(posedge ref_clk_i)
		if (mreq && mack && mwe && maddr[11:8] == 4'h9)
			sz <= msize;
	// ********
	// Access and compare tasks
	// ********
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		do @(posedge ref_clk_i); while (pready !== 1'b1);
		rd = prdata;
		sv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, W0);
		chk(rd, exp);
	endtask
	task automatic wait_on(input int ch);
		int n;
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (n < 3000 && (ch < 0 ? irq : done[ch]) !== 1'b1);
		@(posedge ref_clk_i);
		chk({31'h0, n < 3000}, W1);
	endtask
	task automatic load(input int ch, input logic [31:0] s, input logic [31:0] d,
		input logic [31:0] c);
		mdl.mem[256 + ch * 4] = s;
		mdl.mem[257 + ch * 4] = d;
		mdl.mem[258 + ch * 4] = c;
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		for (int i = 0; i < 96; i++)
			mdl.mem[512 + i] = (i < 32) ? 32'h1111_0000 + i : W0;
		repeat (12) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rdc(`OFF_ENABLE, `RST_WORD);
		rdc(8'h2C, W0);
		chk({30'h0, pready, sv}, 32'h0000_0003);
		apb(1'b1, `OFF_CTLBASE, 32'h0000_07FF);
		rdc(`OFF_CTLBASE, 32'h0000_0400);
		rdc(`OFF_ALTBASE, 32'h0000_0440);
		load(0, 32'h0000_0800, 32'h0000_0900, AUTO2);
		apb(1'b1, `OFF_ENABLE, W1);
		apb(1'b1, `OFF_SWREQ, W1);
		repeat (20) @(posedge ref_clk_i);
		chk(mdl.mem[576], W0);
		busy <= 1'b1;
		apb(1'b1, `OFF_CFG, W1);
		repeat (20) @(posedge ref_clk_i);
		chk(mdl.mem[576], W0);
		busy <= 1'b0;
		slow <= 1'b1;
		wait_on(-1);
		chk(mdl.mem[576], 32'h1111_0000);
		chk(mdl.mem[577], 32'h1111_0001);
		chk({30'h0, sz}, {30'h0, `SIZE_WORD});
		chk(mdl.mem[256], 32'h0000_0808);
		chk(mdl.mem[258] & 32'h0000_3FF7, W0);
		rdc(`OFF_ENABLE, W0);
		load(1, 32'h0000_0840, 32'h0000_0940, 32'h8A00_0031);
		apb(1'b1, `OFF_ENABLE, W2);
		breq <= 4'h2;
		do @(posedge ref_clk_i); while (!(mreq && mack && mwe && maddr == 32'h0000_0940));
		breq <= 4'h0;
		repeat (60) @(posedge ref_clk_i);
		chk(mdl.mem[593], 32'h1111_0011);
		chk(mdl.mem[594], W0);
		breq <= 4'h2;
		wait_on(1);
		chk(mdl.mem[594], 32'h1111_0012);
		breq <= 4'h0;
		apb(1'b1, `OFF_REQMASK, W2);
		load(1, 32'h0000_0840, 32'h0000_0960, 32'h8A00_0011);
		apb(1'b1, `OFF_ENABLE, W2);
		breq <= 4'h2;
		repeat (60) @(posedge ref_clk_i);
		chk(mdl.mem[600], W0);
		apb(1'b1, `OFF_REQMASK, W0);
		wait_on(1);
		chk(mdl.mem[600], 32'h1111_0010);
		breq <= 4'h0;
		fail <= 1'b1;
		load(0, 32'h0000_0800, 32'h0000_0900, AUTO2);
		apb(1'b1, `OFF_ENABLE, W1);
		apb(1'b1, `OFF_SWREQ, W1);
		wait_on(-1);
		repeat (10) @(posedge ref_clk_i);
		rdc(`OFF_ERR, W1);
		chk({31'h0, irq}, W1);
		fail <= 1'b0;
		apb(1'b1, `OFF_ERR, W1);
		rdc(`OFF_ERR, W0);
		chk({31'h0, irq}, W0);
		apb(1'b1, `OFF_BURST, W2);
		load(1, 32'h0000_0840, 32'h0000_0964, 32'h8A00_0011);
		apb(1'b1, `OFF_ENABLE, W2);
		sreq <= 4'h2;
		repeat (60) @(posedge ref_clk_i);
		chk(mdl.mem[601], W0);
		apb(1'b1, `OFF_BURST, W0);
		wait_on(1);
		chk(mdl.mem[601], 32'h1111_0010);
		sreq <= 4'h0;
		load(2, 32'h0000_0808, 32'h0000_0968, 32'hC000_0032);
		apb(1'b1, `OFF_ENABLE, 32'h0000_0004);
		apb(1'b1, `OFF_SWREQ, 32'h0000_0004);
		wait_on(-1);
		chk({30'h0, sz}, W0);
		chk(mdl.mem[264], 32'h0000_080B);
		chk(mdl.mem[265], 32'h0000_0968);
		chk(mdl.mem[602], 32'h1111_0002);
		chk(mdl.mem[266] & 32'h0000_3FF7, W0);
		for (int p = 0; p < 2; p++) begin
			load(2, 32'h0000_0810, 32'h0000_0970 + p * 8, 32'h8A00_0012);
			load(3, 32'h0000_0814, 32'h0000_0974 + p * 8, 32'h8A00_0012);
			busy <= 1'b1;
			apb(1'b1, `OFF_PRIO, p * 8);
			apb(1'b1, `OFF_ENABLE, 32'h0000_000C);
			apb(1'b1, `OFF_SWREQ, 32'h0000_000C);
			apb(1'b0, `OFF_STATUS, W0);
			chk(rd & 32'h0000_001F, 2 + p);
			busy <= 1'b0;
			wait_on(-1);
			wait_on(-1);
			chk(mdl.mem[604 + p * 2], 32'h1111_0004);
			chk(mdl.mem[605 + p * 2], 32'h1111_0005);
		end
		report_and_stop();
	end
	initial begin
		#300000;
		errors++;
		report_and_stop();
	end
endmodule
